// ### common/olcr_pkg.sv
// Package with offsets, field layouts, timings and the state struct of the link control registers
`default_nettype none
package olcr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_LINK_STATUS    = 12'h004;
  localparam logic [11:0] OFF_RESERVED_CTRL  = 12'h008;
  localparam logic [11:0] OFF_FRONT_IO       = 12'h080;
  localparam logic [11:0] OFF_LATCH_IRQ      = 12'h084;
  localparam logic [11:0] OFF_MASTER_CTRL    = 12'h100;
  localparam logic [11:0] OFF_BUS_IRQ        = 12'h104;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLR_SHIFT      = 16;
  localparam int IO_SET_LSB     = 0;
  localparam int IO_CLR_LSB     = 16;
  localparam int IO_PULSE_LSB   = 24;
  localparam int IRQSTAT_LSB    = 8;
  localparam int UPDATE_BIT     = 15;
  localparam int SYSCTL_BIT     = 0;
  localparam int BUSRST_BIT     = 1;
  localparam int OUTRST_BIT     = 2;
  localparam int PORRST_BIT     = 3;
  localparam int REQLVL_LSB     = 4;
  localparam int REQTYPE_BIT    = 6;
  localparam int LED_BIT        = 7;
  localparam int ARB_LSB        = 12;
  localparam int BERR_LSB       = 14;
  localparam int SYSCTL_RD_BIT  = 16;
  localparam int BIRQ_STAT_LSB  = 16;
  localparam int BIRQ_RAW_LSB   = 24;
  localparam int NOTE_LATCH_LSB = 8;
  localparam int NUM_IO         = 7;
  localparam int NUM_BIRQ       = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASTER_RESET = 16'h0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Timing (core clock 40 MHz)
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int BERR_US_0    = 1;
  localparam int BERR_US_1    = 5;
  localparam int BERR_US_2    = 10;
  localparam int BERR_US_3    = 80;
  localparam int ARB_MS_0     = 1;
  localparam int ARB_MS_1     = 5;
  localparam int ARB_MS_2     = 10;
  localparam int ARB_MS_3     = 20;
  localparam int PULSE_PS     = 12500;
  localparam int CLK_PS       = 25000;
  localparam int PULSE_CYC    = (PULSE_PS + CLK_PS - 1) / CLK_PS;
  localparam int BERR_CYC_0   = BERR_US_0 * CLK_MHZ;
  localparam int BERR_CYC_1   = BERR_US_1 * CLK_MHZ;
  localparam int BERR_CYC_2   = BERR_US_2 * CLK_MHZ;
  localparam int BERR_CYC_3   = BERR_US_3 * CLK_MHZ;
  localparam int ARB_CYC_0    = ARB_MS_0 * CLK_MHZ * 1000;
  localparam int ARB_CYC_1    = ARB_MS_1 * CLK_MHZ * 1000;
  localparam int ARB_CYC_2    = ARB_MS_2 * CLK_MHZ * 1000;
  localparam int ARB_CYC_3    = ARB_MS_3 * CLK_MHZ * 1000;
  // ----------------------------------------------------------------
  // State of the register bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] reserved_bits;
    logic [6:0]  static_output_level;
    logic [6:0]  out_drive;
    logic [6:0]  in_prev;
    logic [6:0]  capture;
    logic [6:0]  in_irq_en;
    logic [15:0] master;
    logic [7:0]  bus_irq_en;
    logic        update_blank;
    logic [15:0] note_prev;
    logic        note_valid;
    logic [15:0] note_data;
    logic [31:0] rdata;
    logic        rvalid;
    logic [19:0] powerup_cnt;
    logic        powerup;
    logic        backplane_reset;
    logic        board_reset;
    logic        reset_out;
    logic        bus_clock_run;
    logic        sysctl_active;
  } olcr_state_t;
endpackage : olcr_pkg
`default_nettype wire

// ### logic/olcr_top.sv
// Control and status register bank of the crate controller behind the fibre link
//
// Operation
// - Link status bits 1:0 report receiver locks
// - Reserved register: set low half, clear high
// - Zero write bits leave functions unchanged
// - Seven outputs set/clear, levels read back
// - Input levels read in 22:16, output levels in 6:0, rest zero
// - Bits 30:24 pulse output, inverted when set
// - Capture status read, cleared by writing one
// - Input interrupt enables set/clear, read back
// - Input interrupt status read in 14:8
// - Master config set/clear sixteen bits apart
// - Bus-error timeout 1, 5, 10, 80 us
// - Arbitration timeout 1, 5, 10, 20 ms
// - Request line code selects BR3 to BR0
// - Release policy bit six selects behaviour
// - System controller active by bit or jumper
// - Software-only controller: no clock at power-up
// - Backplane reset at power-up when option+jumper
// - Board reset at power-up when option+jumper
// - Reset output when option+jumper, ORed POR
// - Bus interrupt enables set/clear, read back
// - Raw and enabled bus interrupts read back
// - Enabled status is enable AND line
// - Bus interrupt enables and status read zero after reset, raw lines read as driven
// - Update command blanks pending status briefly
// - Status leading edge sends notification word
`default_nettype none
module olcr_top #(
  parameter int          POWERUP_CYCLES = 4000,
  parameter int          ARB_LIMIT_0    = olcr_pkg::ARB_CYC_0,
  parameter int          ARB_LIMIT_1    = olcr_pkg::ARB_CYC_1,
  parameter int          ARB_LIMIT_2    = olcr_pkg::ARB_CYC_2,
  parameter int          ARB_LIMIT_3    = olcr_pkg::ARB_CYC_3,
  parameter logic [15:0] MASTER_INIT    = olcr_pkg::MASTER_RESET
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  output var  logic [31:0] REG_RDATA,
  output var  logic        REG_RVALID,
  input  wire logic        FAR_RECEIVER_LOCKED,
  input  wire logic        NEAR_RECEIVER_LOCKED,
  input  wire logic [6:0]  FRONT_INPUTS,
  output var  logic [6:0]  FRONT_OUTPUTS,
  input  wire logic [7:1]  BUS_IRQ_LINES,
  input  wire logic        JUMPER_SYSCTL,
  input  wire logic        JUMPER_BUS_RESET,
  input  wire logic        JUMPER_OUT_RESET,
  input  wire logic        JUMPER_OUT_OR_POR,
  input  wire logic        JUMPER_POR,
  output var  logic [15:0] MASTER_CONFIG,
  output var  logic        SYSCTL_ACTIVE,
  output var  logic        BUS_CLOCK_RUN,
  output var  logic        BACKPLANE_RESET,
  output var  logic        BOARD_RESET,
  output var  logic        RESET_OUTPUT,
  output var  logic        NOTIFY_VALID,
  output var  logic [15:0] NOTIFY_DATA
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  olcr_pkg::olcr_state_t st;
  olcr_pkg::olcr_state_t next_st;

  logic        wr_res;
  logic        wr_io;
  logic        wr_latch;
  logic        wr_master;
  logic        wr_birq;
  logic [6:0]  in_irq_stat;
  logic [7:1]  bus_irq_stat;
  logic [15:0] note_vec;
  logic [15:0] master_set;
  logic [15:0] master_clr;
  logic [6:0]  pulse_req;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr_res    = REG_WR && (REG_ADDR == olcr_pkg::OFF_RESERVED_CTRL);
  assign wr_io     = REG_WR && (REG_ADDR == olcr_pkg::OFF_FRONT_IO);
  assign wr_latch  = REG_WR && (REG_ADDR == olcr_pkg::OFF_LATCH_IRQ);
  assign wr_master = REG_WR && (REG_ADDR == olcr_pkg::OFF_MASTER_CTRL);
  assign wr_birq   = REG_WR && (REG_ADDR == olcr_pkg::OFF_BUS_IRQ);

  assign in_irq_stat  = st.capture & st.in_irq_en;
  assign bus_irq_stat = st.bus_irq_en[7:1] & BUS_IRQ_LINES;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    master_set = 16'h0000;
    master_clr = 16'h0000;
    pulse_req  = 7'h00;
    note_vec   = 16'h0000;
    rd_word    = olcr_pkg::ZERO_WORD;

    // Reserved register, set wins nothing: host avoids both at once
    if (wr_res) begin
      next_st.reserved_bits = (st.reserved_bits | REG_WDATA[15:0])
                              & ~REG_WDATA[31:16];
    end

    // Front outputs with static level and single-cycle pulse
    if (wr_io) begin
      next_st.static_output_level = (st.static_output_level
                                     | REG_WDATA[olcr_pkg::IO_SET_LSB +: olcr_pkg::NUM_IO])
                                    & ~REG_WDATA[olcr_pkg::IO_CLR_LSB +: olcr_pkg::NUM_IO];
      pulse_req = REG_WDATA[olcr_pkg::IO_PULSE_LSB +: olcr_pkg::NUM_IO];
    end
    next_st.out_drive = next_st.static_output_level ^ pulse_req;

    // Input capture: rising edge sets, a write of one clears, set wins
    next_st.in_prev = FRONT_INPUTS;
    begin
      logic [6:0] cap_clr;
      cap_clr = wr_latch ? REG_WDATA[olcr_pkg::IO_PULSE_LSB +: olcr_pkg::NUM_IO] : 7'h00;
      next_st.capture = (st.capture & ~cap_clr)
                        | (FRONT_INPUTS & ~st.in_prev);
    end

    // Input interrupt enables
    if (wr_latch) begin
      next_st.in_irq_en = (st.in_irq_en
                           | REG_WDATA[olcr_pkg::IO_SET_LSB +: olcr_pkg::NUM_IO])
                          & ~REG_WDATA[olcr_pkg::IO_CLR_LSB +: olcr_pkg::NUM_IO];
    end

    // Master configuration
    if (wr_master) begin
      master_set = REG_WDATA[15:0];
      master_clr = REG_WDATA[31:16];
    end
    next_st.master = (st.master | master_set) & ~master_clr;

    // Bus interrupt enables, bit 0 is the global enable
    if (wr_birq) begin
      next_st.bus_irq_en = (st.bus_irq_en | REG_WDATA[olcr_pkg::NUM_BIRQ-1:0])
                           & ~REG_WDATA[olcr_pkg::CLR_SHIFT +: olcr_pkg::NUM_BIRQ];
    end

    // Update command blanks the combined status for one cycle
    next_st.update_blank = (wr_latch || wr_birq) && REG_WDATA[olcr_pkg::UPDATE_BIT];

    // Combined status word and its leading-edge notification
    note_vec[olcr_pkg::NOTE_LATCH_LSB +: olcr_pkg::NUM_IO] = in_irq_stat;
    note_vec[7:1] = bus_irq_stat & {7{st.bus_irq_en[0]}};
    if (st.update_blank) begin
      note_vec = 16'h0000;
    end
    next_st.note_prev  = note_vec;
    next_st.note_valid = |(note_vec & ~st.note_prev);
    if (next_st.note_valid) begin
      next_st.note_data = note_vec;
    end

    // Power-up window after reset release
    if (st.powerup_cnt != 20'h00000) begin
      next_st.powerup_cnt = st.powerup_cnt - 20'h00001;
    end
    next_st.powerup = (st.powerup_cnt != 20'h00000);

    // System controller and reset options
    next_st.sysctl_active = st.master[olcr_pkg::SYSCTL_BIT] | JUMPER_SYSCTL;
    next_st.bus_clock_run = JUMPER_SYSCTL
                            | (st.master[olcr_pkg::SYSCTL_BIT] & ~st.powerup);
    next_st.backplane_reset = st.powerup & st.master[olcr_pkg::BUSRST_BIT]
                              & JUMPER_BUS_RESET;
    next_st.board_reset = st.powerup & st.master[olcr_pkg::PORRST_BIT]
                          & JUMPER_POR;
    next_st.reset_out = (st.master[olcr_pkg::OUTRST_BIT] & JUMPER_OUT_RESET)
                        | (JUMPER_OUT_OR_POR & st.board_reset);

    // Read mux
    unique case (REG_ADDR)
      olcr_pkg::OFF_LINK_STATUS: begin
        rd_word[1] = FAR_RECEIVER_LOCKED;
        rd_word[0] = NEAR_RECEIVER_LOCKED;
      end
      olcr_pkg::OFF_RESERVED_CTRL: begin
        rd_word[15:0] = st.reserved_bits;
      end
      olcr_pkg::OFF_FRONT_IO: begin
        rd_word[olcr_pkg::IO_SET_LSB +: olcr_pkg::NUM_IO] = st.static_output_level;
        rd_word[olcr_pkg::IO_CLR_LSB +: olcr_pkg::NUM_IO] = FRONT_INPUTS;
      end
      olcr_pkg::OFF_LATCH_IRQ: begin
        rd_word[olcr_pkg::IO_PULSE_LSB +: olcr_pkg::NUM_IO] = st.capture;
        rd_word[olcr_pkg::IO_CLR_LSB +: olcr_pkg::NUM_IO]   = FRONT_INPUTS;
        rd_word[olcr_pkg::IRQSTAT_LSB +: olcr_pkg::NUM_IO]  = in_irq_stat;
        rd_word[olcr_pkg::IO_SET_LSB +: olcr_pkg::NUM_IO]   = st.in_irq_en;
      end
      olcr_pkg::OFF_MASTER_CTRL: begin
        rd_word[15:0] = st.master;
        rd_word[olcr_pkg::SYSCTL_RD_BIT] = st.master[olcr_pkg::SYSCTL_BIT]
                                           | JUMPER_SYSCTL;
      end
      olcr_pkg::OFF_BUS_IRQ: begin
        rd_word[olcr_pkg::BIRQ_RAW_LSB +: 8]  = {BUS_IRQ_LINES, 1'b0};
        rd_word[olcr_pkg::BIRQ_STAT_LSB +: 8] = {bus_irq_stat, 1'b0};
        rd_word[olcr_pkg::NUM_BIRQ-1:0]       = st.bus_irq_en;
      end
      default: begin
        rd_word = olcr_pkg::ZERO_WORD;
      end
    endcase
    next_st.rvalid = REG_RD;
    if (REG_RD) begin
      next_st.rdata = rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st             <= '0;
      st.master      <= MASTER_INIT;
      st.powerup_cnt <= POWERUP_CYCLES[19:0];
      st.powerup     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Timeout selections
  // ----------------------------------------------------------------
  logic [11:0] berr_limit;
  logic [19:0] arb_limit;
  logic [3:0]  req_line;

  always_comb begin
    unique case (st.master[olcr_pkg::BERR_LSB +: 2])
      2'h0: berr_limit = 12'(olcr_pkg::BERR_CYC_0);
      2'h1: berr_limit = 12'(olcr_pkg::BERR_CYC_1);
      2'h2: berr_limit = 12'(olcr_pkg::BERR_CYC_2);
      2'h3: berr_limit = 12'(olcr_pkg::BERR_CYC_3);
    endcase
    unique case (st.master[olcr_pkg::ARB_LSB +: 2])
      2'h0: arb_limit = 20'(ARB_LIMIT_0);
      2'h1: arb_limit = 20'(ARB_LIMIT_1);
      2'h2: arb_limit = 20'(ARB_LIMIT_2);
      2'h3: arb_limit = 20'(ARB_LIMIT_3);
    endcase
    unique case (st.master[olcr_pkg::REQLVL_LSB +: 2])
      2'h0: req_line = 4'h8;
      2'h1: req_line = 4'h4;
      2'h2: req_line = 4'h2;
      2'h3: req_line = 4'h1;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  logic [11:0] berr_q;
  logic [19:0] arb_q;
  logic [3:0]  req_q;
  logic        policy_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      berr_q   <= 12'h000;
      arb_q    <= 20'h00000;
      req_q    <= 4'h0;
      policy_q <= 1'b0;
    end else begin
      berr_q   <= berr_limit;
      arb_q    <= arb_limit;
      req_q    <= req_line;
      policy_q <= st.master[olcr_pkg::REQTYPE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign REG_RDATA       = st.rdata;
  assign REG_RVALID      = st.rvalid;
  assign FRONT_OUTPUTS   = st.out_drive;
  assign MASTER_CONFIG   = st.master;
  assign SYSCTL_ACTIVE   = st.sysctl_active;
  assign BUS_CLOCK_RUN   = st.bus_clock_run;
  assign BACKPLANE_RESET = st.backplane_reset;
  assign BOARD_RESET     = st.board_reset;
  assign RESET_OUTPUT    = st.reset_out;
  assign NOTIFY_VALID    = st.note_valid;
  assign NOTIFY_DATA     = st.note_data;

endmodule : olcr_top
`default_nettype wire

// ### test/olcr_host_model.sv
// Host-side model issuing single register reads and writes over the link
`default_nettype none
module olcr_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [11:0] addr,
  output var  logic [31:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
  end
  // Callers never set and clear one function in one word
  task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge clk) #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    addr = ~a;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk) #1;
      n++;
    end
    d = (rvalid === 1'b1) ? rdata : 32'hXXXX_XXXX;
  endtask : read_reg
endmodule : olcr_host_model
`default_nettype wire

// ### test/olcr_top_properties.sv
// Port-level checks of the link control register bank
`default_nettype none
module olcr_top_properties (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic        FAR_RECEIVER_LOCKED,
  input wire logic        NEAR_RECEIVER_LOCKED,
  input wire logic [6:0]  FRONT_INPUTS,
  input wire logic [6:0]  FRONT_OUTPUTS,
  input wire logic [7:1]  BUS_IRQ_LINES,
  input wire logic        JUMPER_SYSCTL,
  input wire logic [15:0] MASTER_CONFIG,
  input wire logic        SYSCTL_ACTIVE,
  input wire logic        BUS_CLOCK_RUN,
  input wire logic        BACKPLANE_RESET
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  link_status_a : assert property (
    REG_RD && REG_ADDR == olcr_pkg::OFF_LINK_STATUS |=>
    REG_RDATA == {30'h0, $past(FAR_RECEIVER_LOCKED), $past(NEAR_RECEIVER_LOCKED)})
    else $error("link status read wrong");
  reserved_upper_a : assert property (
    REG_RD && REG_ADDR == olcr_pkg::OFF_RESERVED_CTRL |=> REG_RDATA[31:16] == 16'h0000)
    else $error("reserved register upper half not zero");
  io_read_a : assert property (
    REG_RD && REG_ADDR == olcr_pkg::OFF_FRONT_IO |=> REG_RDATA[22:16] == $past(FRONT_INPUTS)
    && REG_RDATA[15:7] == 9'h000 && REG_RDATA[31:23] == 9'h000)
    else $error("front io read wrong");
  io_setclr_a : assert property (
    REG_WR && REG_ADDR == olcr_pkg::OFF_FRONT_IO && REG_WDATA[30:24] == 7'h00 && !$past(REG_WR)
    |=> FRONT_OUTPUTS == (($past(FRONT_OUTPUTS) | $past(REG_WDATA[6:0]))
    & ~$past(REG_WDATA[22:16])))
    else $error("output set or clear wrong");
  io_pulse_a : assert property (
    REG_WR && REG_ADDR == olcr_pkg::OFF_FRONT_IO && REG_WDATA[22:0] == 23'h000000
    && !$past(REG_WR) |=> FRONT_OUTPUTS == ($past(FRONT_OUTPUTS) ^ $past(REG_WDATA[30:24]))
    ##1 FRONT_OUTPUTS == $past(FRONT_OUTPUTS, 2))
    else $error("output pulse wrong");
  master_write_a : assert property (
    REG_WR && REG_ADDR == olcr_pkg::OFF_MASTER_CTRL |=> (MASTER_CONFIG & 16'hF0FF) ==
    ((($past(MASTER_CONFIG) | $past(REG_WDATA[15:0])) & ~$past(REG_WDATA[31:16])) & 16'hF0FF))
    else $error("master config update wrong");
  sysctl_or_a : assert property (
    1'b1 |=> SYSCTL_ACTIVE == $past(MASTER_CONFIG[0] | JUMPER_SYSCTL))
    else $error("system controller state wrong");
  birq_read_a : assert property (
    REG_RD && REG_ADDR == olcr_pkg::OFF_BUS_IRQ |=> REG_RDATA[31:25] == $past(BUS_IRQ_LINES)
    && REG_RDATA[23:17] == (REG_RDATA[31:25] & REG_RDATA[7:1]) && REG_RDATA[24] == 1'b0
    && REG_RDATA[16:8] == 9'h000)
    else $error("bus interrupt read wrong");
  bus_clock_a : assert property (
    BACKPLANE_RESET && !$past(JUMPER_SYSCTL) |-> !BUS_CLOCK_RUN)
    else $error("bus clock runs during power-up");
endmodule : olcr_top_properties
bind olcr_top olcr_top_properties olcr_top_properties_i (.*);
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench of the link control register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} olcr_row_t;
  logic CORE_CLK = 1'b0, RESET_N = 1'b0, REG_WR, REG_RD, REG_RVALID, FAR_RECEIVER_LOCKED = 1'b1;
  logic NEAR_RECEIVER_LOCKED = 1'b0, JUMPER_SYSCTL = 1'b0, JUMPER_BUS_RESET = 1'b1;
  logic JUMPER_OUT_RESET = 1'b1, JUMPER_OUT_OR_POR = 1'b0, JUMPER_POR = 1'b1, SYSCTL_ACTIVE;
  logic BUS_CLOCK_RUN, BACKPLANE_RESET, BOARD_RESET, RESET_OUTPUT, NOTIFY_VALID, seen;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, rd;
  logic [6:0]  FRONT_INPUTS = 7'h00, FRONT_OUTPUTS;
  logic [7:1]  BUS_IRQ_LINES = 7'h00;
  logic [15:0] MASTER_CONFIG, NOTIFY_DATA;
  int          n_mismatch = 0, n_tests = 0;
  olcr_row_t   rows [14] = '{
    '{12'h008, 32'h0000_A5A5, 32'h0000_A5A5}, '{12'h008, 32'h0005_0000, 32'h0000_A5A0},
    '{12'h008, 32'h0000_0000, 32'h0000_A5A0}, '{12'h080, 32'h0000_0055, 32'h002A_0055},
    '{12'h080, 32'h0041_0000, 32'h002A_0014}, '{12'h084, 32'h0000_007F, 32'h2A2A_2A7F},
    '{12'h084, 32'h2A00_0000, 32'h002A_007F}, '{12'h084, 32'h007F_0000, 32'h002A_0000},
    '{12'h100, 32'h0000_F074, 32'h0001_F075}, '{12'h100, 32'hF074_0000, 32'h0001_0001},
    '{12'h104, 32'h0000_00FF, 32'hAAAA_00FF}, '{12'h104, 32'h00A0_0000, 32'hAA0A_005F},
    '{12'h004, 32'h0000_0000, 32'h0000_0002}, '{12'h00C, 32'hFFFF_FFFF, 32'h0000_0000}};
  always #12.5 CORE_CLK = ~CORE_CLK;
  olcr_top #(.POWERUP_CYCLES(8), .ARB_LIMIT_0(4), .ARB_LIMIT_1(8), .ARB_LIMIT_2(12),
    .ARB_LIMIT_3(20), .MASTER_INIT(16'h000F)) olcr_top_i (.*);
  olcr_host_model olcr_host_model_i (.clk(CORE_CLK), .rdata(REG_RDATA), .rvalid(REG_RVALID),
    .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR), .wdata(REG_WDATA));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_notify(output logic hit);
    hit = 1'b0;
    repeat (8) begin
      @(posedge CORE_CLK) #1;
      if (NOTIFY_VALID === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask : wait_notify
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    #(25 * 4000);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge CORE_CLK);
    #1 RESET_N = 1'b1;
    repeat (2) @(posedge CORE_CLK);
    #1;
    check("backplane reset", 1, BACKPLANE_RESET);
    check("board reset", 1, BOARD_RESET);
    check("reset output", 1, RESET_OUTPUT);
    check("bus clock off", 0, BUS_CLOCK_RUN);
    repeat (12) @(posedge CORE_CLK);
    #1;
    check("backplane reset end", 0, BACKPLANE_RESET);
    check("board reset end", 0, BOARD_RESET);
    check("bus clock on", 1, BUS_CLOCK_RUN);
    olcr_host_model_i.read_reg(12'h104, rd);
    check("bus irq after reset", 32'h0000_0000, rd);
    olcr_host_model_i.read_reg(12'h100, rd);
    check("master after reset", 32'h0001_000F, rd);
    olcr_host_model_i.write_reg(12'h100, 32'h000E_0000);
    olcr_host_model_i.read_reg(12'h100, rd);
    check("options cleared", 32'h0001_0001, rd);
    check("reset output off", 0, RESET_OUTPUT);
    $display("test reset done");
    FRONT_INPUTS = 7'h2A;
    BUS_IRQ_LINES = 7'h55;
    foreach (rows[i]) begin
      olcr_host_model_i.write_reg(rows[i].a, rows[i].d);
      olcr_host_model_i.read_reg(rows[i].a, rd);
      check($sformatf("row %0d", i), rows[i].e, rd);
    end
    $display("test table done");
    olcr_host_model_i.write_reg(12'h080, 32'h0500_0000);
    check("pulse on", 32'h11, FRONT_OUTPUTS);
    @(posedge CORE_CLK) #1;
    check("pulse off", 32'h14, FRONT_OUTPUTS);
    $display("test pulse done");
    olcr_host_model_i.write_reg(12'h084, 32'h0000_0041);
    FRONT_INPUTS = 7'h6B;
    wait_notify(seen);
    check("notify sent", 1, seen);
    check("notify inputs", 32'h41, {25'h0, NOTIFY_DATA[14:8]});
    olcr_host_model_i.write_reg(12'h084, 32'h0000_8000);
    wait_notify(seen);
    check("update notify", 1, seen);
    $display("test notify done");
    JUMPER_SYSCTL = 1'b1;
    olcr_host_model_i.write_reg(12'h100, 32'h0001_0000);
    olcr_host_model_i.read_reg(12'h100, rd);
    check("jumper controller", 32'h0001_0000, rd);
    $display("test jumper done");
    FAR_RECEIVER_LOCKED = 1'b0;
    NEAR_RECEIVER_LOCKED = 1'b1;
    olcr_host_model_i.read_reg(12'h004, rd);
    check("link status swapped", 32'h0000_0001, rd);
    $display("test link status done");
    close_out;
  end
endmodule : tb
`default_nettype wire
